// ===== lcc_consts.svh
// Constants for the LED channel control register bank.
// Assumes inclusion by bare name from the package and the top module.
`ifndef LCC_CONSTS_SVH
`define LCC_CONSTS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define LCC_ADDR_CH4 8'h0B
`define LCC_ADDR_CH5 8'h0C
`define LCC_ADDR_CH6 8'h0D
`define LCC_CFG_RESET 8'h00
`define LCC_RD_UNMAPPED 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LCC_FADER_MSB 7
`define LCC_FADER_LSB 5
`define LCC_COLOR_HOLD_BIT 4
`define LCC_CURVE_BIT 3
`define LCC_SUPPLY_BIT 2
`define LCC_RSVD_MSB 1
`define LCC_RSVD_LSB 0

// ----------------------------------------
// Fader select codes
// ----------------------------------------
`define LCC_SEL_NONE0 3'h0
`define LCC_SEL_F1 3'h1
`define LCC_SEL_F2 3'h2
`define LCC_SEL_F3 3'h3
`define LCC_SEL_NONE4 3'h4
`define LCC_SEL_PWM 3'h5
`define LCC_SEL_NONE6 3'h6
`define LCC_SEL_NONE7 3'h7

`endif

// ===== lcc_pkg.sv
// Types shared by the LED channel control register bank.
// Assumes lcc_consts.svh is on the include path.
`include "lcc_consts.svh"

package lcc_pkg;

  // ----------------------------------------
  // Register layout, one per channel
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] faderSelect;
    logic colorHold;
    logic curveSelect;
    logic supplySelect;
    logic [1:0] reserved;
  } lcc_cfg_t;

  // Decoded scaling source, one-hot
  typedef enum logic [4:0] {
    LCC_SRC_NONE = 5'b00001,
    LCC_SRC_F1 = 5'b00010,
    LCC_SRC_F2 = 5'b00100,
    LCC_SRC_F3 = 5'b01000,
    LCC_SRC_PWM = 5'b10000
  } lcc_src_t;

  // Per-channel drive toward the output stage
  typedef struct packed {
    logic [7:0] duty;
    logic faderActive;
    logic colorHold;
    logic curveExp;
    logic supplyExt;
  } lcc_drive_t;

endpackage

// ===== lcc_led_channel_control_regs.sv
// Control registers and drive path for LED channels 4, 5 and 6.
// Assumes a host-side serial slave presents single-cycle register
// strobes synchronous to clk, and duty inputs synchronous to clk.
//
// Operation
// - Fader codes 1h, 2h, 3h route channel through master fader one, two, three.
// - Code 5h scales channel by the external PWM input duty level.
// - Codes 0h, 4h, 6h, 7h apply no fader; reset value is 0h.
// - Colour-hold bit 4 set scales proportionally so RGB colour stays constant.
// - Colour-hold bit cleared, its reset value, applies no ratiometric scaling.
// - Bit 3 clear selects linear curve, set selects exponential; resets clear.
// - Chosen curve applies to both engine-driven and direct register duty.
// - Bit 2 clear means charge-pump supply, set means external supply; resets clear.
// - Channel 4 at Bh, 5 at Ch, 6 at Dh, each reset to zero.
`timescale 1ns/1ps
`default_nettype none
`include "lcc_consts.svh"

module lcc_led_channel_control_regs
  import lcc_pkg::*;
#(
  parameter int NUM_CH = 3
) (
  input wire logic clk, // 25 MHz device clock
  input wire logic reset_n, // Async reset, active low
  input wire logic regWrEn, // Register write strobe
  input wire logic regRdEn, // Register read strobe
  input wire logic [7:0] regAddr, // Register address
  input wire logic [7:0] regWrData, // Write data
  output logic [7:0] regRdData, // Read data, held
  output logic regRdValid, // Read data valid pulse
  input wire logic [7:0] fader1Level, // Master fader one
  input wire logic [7:0] fader2Level, // Master fader two
  input wire logic [7:0] fader3Level, // Master fader three
  input wire logic [7:0] pwmInDuty, // Measured PWM input duty
  input wire logic [NUM_CH-1:0] engineActive, // Engine owns channel
  input wire logic [NUM_CH-1:0][7:0] engineDuty, // Engine duty
  input wire logic [NUM_CH-1:0][7:0] directDuty, // Direct PWM duty
  output lcc_drive_t [NUM_CH-1:0] chDrive // Per-channel drive
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Address of a channel's register
  function automatic logic [7:0] chAddr(input int idx);
    logic [7:0] a;
    a = `LCC_ADDR_CH4;
    case (idx)
      0: a = `LCC_ADDR_CH4;
      1: a = `LCC_ADDR_CH5;
      2: a = `LCC_ADDR_CH6;
      default: a = `LCC_ADDR_CH4;
    endcase
    return a;
  endfunction

  // Fader code to scaling source
  function automatic lcc_src_t decodeSrc(input logic [2:0] code);
    lcc_src_t s;
    s = LCC_SRC_NONE;
    case (code)
      `LCC_SEL_F1: s = LCC_SRC_F1;
      `LCC_SEL_F2: s = LCC_SRC_F2;
      `LCC_SEL_F3: s = LCC_SRC_F3;
      `LCC_SEL_PWM: s = LCC_SRC_PWM;
      default: s = LCC_SRC_NONE;
    endcase
    return s;
  endfunction

  // Product scaled so that 255 acts as unity
  function automatic logic [7:0] scale8(input logic [7:0] a,
                                        input logic [7:0] b);
    logic [15:0] p;
    p = 16'(a * b) + {8'h00, a};
    return p[15:8];
  endfunction

  // Square-law curve, monotonic, 0 maps to 0 and 255 to 255
  function automatic logic [7:0] expCurve(input logic [7:0] x);
    return scale8(x, x);
  endfunction

  // Smaller of two duties
  function automatic logic [7:0] min8(input logic [7:0] a,
                                      input logic [7:0] b);
    return (a < b) ? a : b;
  endfunction

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  lcc_cfg_t [NUM_CH-1:0] cfg_q;
  logic [NUM_CH-1:0] hit;

  // Address decode per channel
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      hit[i] = (regAddr == chAddr(i));
    end
  end

  // Register writes, all eight bits stored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (regWrEn && hit[i]) begin
          cfg_q[i] <= lcc_cfg_t'(regWrData);
        end
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0] rdMux;

  // Unmapped addresses read as zero
  always_comb begin
    rdMux = `LCC_RD_UNMAPPED;
    for (int i = 0; i < NUM_CH; i++) begin
      if (hit[i]) begin
        rdMux = cfg_q[i];
      end
    end
  end

  // Read data registered; a same-cycle write shows next read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        regRdData <= rdMux;
      end
    end
  end

  // ----------------------------------------
  // Per-channel drive path
  // ----------------------------------------
  for (genvar g = 0; g < NUM_CH; g++) begin : gCh
    lcc_src_t src;
    logic [7:0] srcDuty;
    logic [7:0] curved;
    logic [7:0] level;
    logic [7:0] faded;

    // Engine and direct duty share the same curve
    always_comb begin
      srcDuty = engineActive[g] ? engineDuty[g] : directDuty[g];
      curved = cfg_q[g].curveSelect ? expCurve(srcDuty) : srcDuty;
    end

    // Fader level selection from this channel's own code
    always_comb begin
      src = decodeSrc(cfg_q[g].faderSelect);
      level = 8'hFF;
      case (src)
        LCC_SRC_F1: level = fader1Level;
        LCC_SRC_F2: level = fader2Level;
        LCC_SRC_F3: level = fader3Level;
        LCC_SRC_PWM: level = pwmInDuty;
        default: level = 8'hFF;
      endcase
    end

    // Proportional scaling keeps colour ratios; otherwise a cap
    always_comb begin
      if (src == LCC_SRC_NONE) begin
        faded = curved;
      end else if (cfg_q[g].colorHold) begin
        faded = scale8(curved, level);
      end else begin
        faded = min8(curved, level);
      end
    end

    // Drive outputs straight from flops
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        chDrive[g] <= '0;
      end else begin
        chDrive[g].duty <= faded;
        chDrive[g].faderActive <= (src != LCC_SRC_NONE);
        chDrive[g].colorHold <= cfg_q[g].colorHold;
        chDrive[g].curveExp <= cfg_q[g].curveSelect;
        chDrive[g].supplyExt <= cfg_q[g].supplySelect;
      end
    end
  end

endmodule // lcc_led_channel_control_regs

`default_nettype wire

// ===== lcc_monitor.sv
// Checker for the channel control register bank.
// Assumes it is bound onto the bank's top module.
`timescale 1ns/1ps
`default_nettype none

module lcc_monitor
  import lcc_pkg::*;
#(
  parameter int NUM_CH = 3
) (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic regWrEn, // Write strobe
  input wire logic regRdEn, // Read strobe
  input wire logic [7:0] regAddr, // Address
  input wire logic [7:0] regWrData, // Write data
  input wire logic [7:0] regRdData, // Read data
  input wire logic regRdValid, // Read valid
  input wire lcc_drive_t [NUM_CH-1:0] chDrive // Drive
);
  // ----
  // Properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A write lands in config at once, in the drive one edge later
  sequence s_wr(a);
    regWrEn && regAddr == a;
  endsequence
  property p_rdv; regRdEn |=> regRdValid; endproperty
  property p_nrd; !regRdEn |=> !regRdValid && $stable(regRdData); endproperty
  property p_unm; regRdEn && !(regAddr inside {[8'h0B:8'h0D]}) |=> regRdData == 8'h00; endproperty
  property p_fad; s_wr(8'h0B) ##0 regWrData[7:5] inside {3'h1, 3'h2, 3'h3, 3'h5} |-> ##2 chDrive[0].faderActive;
  endproperty
  property p_nof; s_wr(8'h0C) ##0 regWrData[7:5] inside {3'h0, 3'h4, 3'h6, 3'h7} |-> ##2 !chDrive[1].faderActive;
  endproperty
  property p_hld; s_wr(8'h0D) |-> ##2 chDrive[2].colorHold == $past(regWrData[4], 2); endproperty
  property p_crv; s_wr(8'h0B) |-> ##2 chDrive[0].curveExp == $past(regWrData[3], 2); endproperty
  property p_sup; s_wr(8'h0C) |-> ##2 chDrive[1].supplyExt == $past(regWrData[2], 2); endproperty
  a_rdv: assert property (p_rdv) else $error("read valid missing");
  a_nrd: assert property (p_nrd) else $error("read data moved");
  a_unm: assert property (p_unm) else $error("unmapped read nonzero");
  a_fad: assert property (p_fad) else $error("fader not active");
  a_nof: assert property (p_nof) else $error("fader active");
  a_hld: assert property (p_hld) else $error("colour hold wrong");
  a_crv: assert property (p_crv) else $error("curve wrong");
  a_sup: assert property (p_sup) else $error("supply wrong");
endmodule // lcc_monitor

bind lcc_led_channel_control_regs lcc_monitor #(.NUM_CH(NUM_CH)) uMon (.clk(clk), .reset_n(reset_n),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
  .regRdData(regRdData), .regRdValid(regRdValid), .chDrive(chDrive));
`default_nettype wire

// ===== lcc_led_channel_control_regs_bench.sv
// Random self-checking bench for the channel control register bank.
// Assumes package, design and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module lcc_led_channel_control_regs_bench
  import lcc_pkg::*;
;
  logic clk = 0, reset_n = 0, wrEn = 0, rdEn = 0, rdValid, expValid;
  logic [7:0] addr = '0, wd = '0, f1 = '0, f2 = '0, f3 = '0, pwm = '0, rdData, expRd;
  logic [2:0] engAct = '0;
  logic [2:0][7:0] engD = '0, dirD = '0;
  lcc_drive_t [2:0] drv, expD;
  logic [7:0] cfg [3] = '{default: '0};
  logic [31:0] seed = 32'h00012433;
  int err_total = 0, cmp_count = 0, cyc = 0;

  lcc_led_channel_control_regs #(.NUM_CH(3)) dut (.clk(clk), .reset_n(reset_n), .regWrEn(wrEn),
    .regRdEn(rdEn), .regAddr(addr), .regWrData(wd), .regRdData(rdData), .regRdValid(rdValid),
    .fader1Level(f1), .fader2Level(f2), .fader3Level(f3), .pwmInDuty(pwm), .engineActive(engAct),
    .engineDuty(engD), .directDuty(dirD), .chDrive(drv));

  // ----
  // Model and helpers
  // ----
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Square-law curve, then cap or proportional scale by the chosen fader
  function automatic lcc_drive_t model(logic [7:0] c, int s);
    int v, l;
    v = c[3] ? (s * s + s) >> 8 : s;
    l = c[7:5] == 3'h5 ? pwm : c[7:5] == 3'h1 ? f1 : c[7:5] == 3'h2 ? f2 : c[7:5] == 3'h3 ? f3 : -1;
    if (l >= 0) v = c[4] ? (v * l + v) >> 8 : (v < l ? v : l);
    return {8'(v), l >= 0, c[4], c[3], c[2]};
  endfunction

  task automatic chk(string n, logic [11:0] e, logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic stop_test();
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Clock, and a ceiling well above the 2000-odd cycles of the run
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      stop_test();
    end
  end

  // Reset, then read all three, then random traffic checked every edge
  initial begin
    logic [31:0] r;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 3; k++) chk("rstDrive", '0, drv[k]);
    reset_n <= 1'h1;
    for (int i = 0; i < 2003; i++) begin
      @(posedge clk);
      for (int k = 0; k < 3; k++) expD[k] = model(cfg[k], engAct[k] ? engD[k] : dirD[k]);
      expValid = rdEn;
      if (rdEn) expRd = addr inside {[8'h0B:8'h0D]} ? cfg[addr - 8'h0B] : 8'h00;
      if (wrEn && addr inside {[8'h0B:8'h0D]}) cfg[addr - 8'h0B] = wd;
      r = rnd();
      wrEn <= i > 2 && r[0];
      rdEn <= i <= 2 || r[1];
      addr <= i <= 2 ? 8'h0B + 8'(i) : 8'h09 + 8'(r[10:8]);
      wd <= r[31:24];
      {f1, f2, f3, pwm} <= rnd();
      r = rnd();
      {engAct, engD} <= r[26:0];
      r = rnd();
      dirD <= r[23:0];
      #1;
      for (int k = 0; k < 3; k++) chk("chDrive", expD[k], drv[k]);
      chk("rdValid", 12'(expValid), 12'(rdValid));
      if (rdValid === 1'h1) chk("rdData", 12'(expRd), 12'(rdData));
    end
    stop_test();
  end
endmodule // lcc_led_channel_control_regs_bench
`default_nettype wire
